// [rtl/dacr_top.sv]
// Shadowed configuration register bank for a dual 8-bit converter with two channel paths.
module dacr_top
    import dacr_pkg::*;
#(
    parameter int SAMPLE_W = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [dacr_pkg::DATA_W-1:0] sampleA,
    input wire logic [dacr_pkg::DATA_W-1:0] sampleB,
    input wire logic sampleValid,
    output logic [dacr_pkg::DATA_W-1:0] dataOutA,
    output logic [dacr_pkg::DATA_W-1:0] dataOutB,
    output logic dataValidA,
    output logic dataValidB,
    output logic [1:0] powerMode,
    output logic stabilizerEnable,
    output logic commonModeEnable,
    output logic dataClockOutputInvert,
    output logic [4:0] referenceScale,
    output logic analogDisconnectA,
    output logic analogDisconnectB
);
    import dacr_pkg::*;

    if (SAMPLE_W != DATA_W) begin : gen_width_check
        $error("dacr_top: the register layout serves only 8-bit samples");
    end

    logic [1:0] chanSelect;
    logic transferPending;
    dacr_chan_cfg_s shadowCfg [2];
    dacr_chan_cfg_s activeCfg [2];
    logic [1:0] shadowPowerMode;
    logic shadowStabilizer;
    logic shadowCmEnable;
    logic shadowClkInvert;
    logic [4:0] shadowRefScale;
    logic readChan;
    logic [7:0] next_regRdData;
    logic [SIG_W-1:0] signature [2];

    // Applies one byte write to a channel's shadow copy.
    function automatic dacr_chan_cfg_s chanWrite(input dacr_chan_cfg_s cfg,
                                                 input logic [7:0] addr,
                                                 input logic [7:0] data);
        dacr_chan_cfg_s res;
        res = cfg;
        unique case (addr)
            ADDR_TEST: begin
                res.testSel = dacr_test_sel_e'(data[2:0]);
                res.rstLong = data[RST_LONG_BIT];
                res.rstShort = data[RST_SHORT_BIT];
            end
            ADDR_SELF_TEST: begin
                res.stInit = data[ST_INIT_BIT];
                res.stEnable = data[ST_ENABLE_BIT];
            end
            ADDR_INPUT: res.disconnect = data[DISCONNECT_BIT];
            ADDR_OFFSET: res.offset = data[3:0];
            ADDR_OUT_FORMAT: begin
                res.outEnable = data[OUT_ENABLE_BIT];
                res.outInvert = data[OUT_INVERT_BIT];
                res.format = dacr_format_e'(data[1:0]);
            end
            default: res = cfg;
        endcase
        return res;
    endfunction

    // Reads back the local bits of a channel's shadow copy.
    function automatic logic [7:0] chanRead(input dacr_chan_cfg_s cfg,
                                            input logic [7:0] addr);
        logic [7:0] res;
        res = 8'h00;
        unique case (addr)
            ADDR_TEST: begin
                res[2:0] = cfg.testSel;
                res[RST_LONG_BIT] = cfg.rstLong;
                res[RST_SHORT_BIT] = cfg.rstShort;
            end
            ADDR_SELF_TEST: begin
                res[ST_INIT_BIT] = cfg.stInit;
                res[ST_ENABLE_BIT] = cfg.stEnable;
            end
            ADDR_INPUT: res[DISCONNECT_BIT] = cfg.disconnect;
            ADDR_OFFSET: res[3:0] = cfg.offset;
            ADDR_OUT_FORMAT: begin
                res[OUT_ENABLE_BIT] = cfg.outEnable;
                res[OUT_INVERT_BIT] = cfg.outInvert;
                res[1:0] = cfg.format;
            end
            default: res = 8'h00;
        endcase
        return res;
    endfunction

    always_ff @(posedge clk) begin
        if (!rstn) begin
            chanSelect <= RST_CHAN_INDEX;
        end else if (regWrEn && regAddr == ADDR_CHAN_INDEX) begin
            chanSelect <= regWrData[1:0];
        end
    end

    // A command arriving as the previous one is applied still leaves the bit set.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            transferPending <= 1'b0;
        end else begin
            transferPending <= regWrEn && regAddr == ADDR_TRANSFER
                && regWrData == TRANSFER_CMD;
        end
    end

    for (genvar ch = 0; ch < 2; ch++) begin : gen_shadow
        always_ff @(posedge clk) begin
            if (!rstn) begin
                shadowCfg[ch] <= CHAN_CFG_RESET;
            end else if (regWrEn && chanSelect[ch]) begin
                shadowCfg[ch] <= chanWrite(shadowCfg[ch], regAddr, regWrData);
            end
        end

        always_ff @(posedge clk) begin
            if (!rstn) begin
                activeCfg[ch] <= CHAN_CFG_RESET;
            end else if (transferPending) begin
                activeCfg[ch] <= shadowCfg[ch];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            shadowPowerMode <= RST_POWER_MODE;
            shadowStabilizer <= RST_STABILIZER;
            shadowCmEnable <= 1'b0;
            shadowClkInvert <= 1'b0;
            shadowRefScale <= RST_REF_SCALE;
        end else if (regWrEn) begin
            unique case (regAddr)
                ADDR_MODES: shadowPowerMode <= regWrData[1:0];
                ADDR_CLOCK: shadowStabilizer <= regWrData[STAB_BIT];
                ADDR_INPUT: shadowCmEnable <= regWrData[CM_ENABLE_BIT];
                ADDR_OUT_PHASE: shadowClkInvert <= regWrData[CLK_INVERT_BIT];
                ADDR_REF_SCALE: shadowRefScale <= regWrData[4:0];
                default: shadowPowerMode <= shadowPowerMode;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            powerMode <= RST_POWER_MODE;
            stabilizerEnable <= RST_STABILIZER;
            commonModeEnable <= 1'b0;
            dataClockOutputInvert <= 1'b0;
            referenceScale <= RST_REF_SCALE;
        end else if (transferPending) begin
            powerMode <= shadowPowerMode;
            stabilizerEnable <= shadowStabilizer;
            commonModeEnable <= shadowCmEnable;
            dataClockOutputInvert <= shadowClkInvert;
            referenceScale <= shadowRefScale;
        end
    end

    // Channel A answers whenever it is selected, including when both are.
    assign readChan = !chanSelect[CHAN_A_BIT];

    always_comb begin
        next_regRdData = chanRead(shadowCfg[readChan], regAddr);
        unique case (regAddr)
            ADDR_CHAN_INDEX: next_regRdData = {6'h00, chanSelect};
            ADDR_TRANSFER: next_regRdData = {7'h00, transferPending};
            ADDR_MODES: next_regRdData = {6'h00, shadowPowerMode};
            ADDR_CLOCK: next_regRdData[STAB_BIT] = shadowStabilizer;
            ADDR_INPUT: next_regRdData[CM_ENABLE_BIT] = shadowCmEnable;
            ADDR_OUT_PHASE: next_regRdData[CLK_INVERT_BIT] = shadowClkInvert;
            ADDR_REF_SCALE: next_regRdData = {3'h0, shadowRefScale};
            ADDR_SIG_LOW: next_regRdData = signature[readChan][7:0];
            ADDR_SIG_HIGH: next_regRdData = signature[readChan][15:8];
            default: next_regRdData = next_regRdData;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRdEn) begin
            regRdData <= next_regRdData;
        end
    end

    dacr_chan_if chanIfA();
    dacr_chan_if chanIfB();

    assign chanIfA.cfg = activeCfg[0];
    assign chanIfB.cfg = activeCfg[1];
    assign chanIfA.powerDown = powerMode == PWR_DOWN;
    assign chanIfB.powerDown = powerMode == PWR_DOWN;
    assign signature[0] = chanIfA.signature;
    assign signature[1] = chanIfB.signature;
    assign analogDisconnectA = activeCfg[0].disconnect;
    assign analogDisconnectB = activeCfg[1].disconnect;

    dacr_channel uChanA (
        .clk(clk),
        .rstn(rstn),
        .cfgPort(chanIfA.chan),
        .sampleIn(sampleA),
        .sampleValid(sampleValid),
        .dataOut(dataOutA),
        .dataValid(dataValidA)
    );

    dacr_channel uChanB (
        .clk(clk),
        .rstn(rstn),
        .cfgPort(chanIfB.chan),
        .sampleIn(sampleB),
        .sampleValid(sampleValid),
        .dataOut(dataOutB),
        .dataValid(dataValidB)
    );

endmodule // dacr_top

// [rtl/dacr_pkg.sv]
// Constants, field layouts and types shared by the converter configuration register bank.
package dacr_pkg;

    localparam int DATA_W = 8;
    localparam int SIG_W = 16;

    // Register addresses.
    localparam logic [7:0] ADDR_CHAN_INDEX = 8'h05;
    localparam logic [7:0] ADDR_TRANSFER = 8'hff;
    localparam logic [7:0] ADDR_MODES = 8'h08;
    localparam logic [7:0] ADDR_CLOCK = 8'h09;
    localparam logic [7:0] ADDR_TEST = 8'h0d;
    localparam logic [7:0] ADDR_SELF_TEST = 8'h0e;
    localparam logic [7:0] ADDR_INPUT = 8'h0f;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_OUT_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_OUT_PHASE = 8'h16;
    localparam logic [7:0] ADDR_REF_SCALE = 8'h18;
    localparam logic [7:0] ADDR_SIG_LOW = 8'h24;
    localparam logic [7:0] ADDR_SIG_HIGH = 8'h25;

    // Reset values and the transfer command code.
    localparam logic [1:0] RST_CHAN_INDEX = 2'h3;
    localparam logic [1:0] RST_POWER_MODE = 2'h0;
    localparam logic RST_STABILIZER = 1'b1;
    localparam logic [4:0] RST_REF_SCALE = 5'h00;
    localparam logic [7:0] TRANSFER_CMD = 8'h01;

    // Field positions.
    localparam int CHAN_A_BIT = 0;
    localparam int CHAN_B_BIT = 1;
    localparam int STAB_BIT = 0;
    localparam int RST_LONG_BIT = 5;
    localparam int RST_SHORT_BIT = 4;
    localparam int ST_INIT_BIT = 2;
    localparam int ST_ENABLE_BIT = 0;
    localparam int DISCONNECT_BIT = 2;
    localparam int CM_ENABLE_BIT = 1;
    localparam int OUT_ENABLE_BIT = 4;
    localparam int OUT_INVERT_BIT = 2;
    localparam int CLK_INVERT_BIT = 7;

    // Power modes; codes 10 and 11 are reserved and treated as running.
    localparam logic [1:0] PWR_RUN = 2'h0;
    localparam logic [1:0] PWR_DOWN = 2'h1;

    typedef enum logic [2:0] {
        TEST_OFF = 3'h0,
        TEST_MIDSCALE = 3'h1,
        TEST_POS_FULL = 3'h2,
        TEST_NEG_FULL = 3'h3,
        TEST_CHECKER = 3'h4,
        TEST_LONG_PRBS = 3'h5,
        TEST_SHORT_PRBS = 3'h6,
        TEST_TOGGLE = 3'h7
    } dacr_test_sel_e;

    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'h0,
        FMT_TWOS_COMP = 2'h1,
        FMT_GRAY = 2'h2,
        FMT_RESERVED = 2'h3
    } dacr_format_e;

    // Pattern words, all in offset binary before formatting.
    localparam logic [7:0] PAT_MIDSCALE = 8'h80;
    localparam logic [7:0] PAT_POS_FULL = 8'hff;
    localparam logic [7:0] PAT_NEG_FULL = 8'h00;
    localparam logic [7:0] PAT_CHECK_A = 8'h55;
    localparam logic [7:0] PAT_CHECK_B = 8'haa;

    // Pseudo-random generators: lengths and feedback taps.
    localparam int LONG_LEN = 23;
    localparam int LONG_TAP = 18;
    localparam int SHORT_LEN = 9;
    localparam int SHORT_TAP = 5;
    localparam logic [SIG_W-1:0] SIG_POLY = 16'h1021;

    typedef struct packed {
        dacr_test_sel_e testSel;
        logic rstLong;
        logic rstShort;
        logic stInit;
        logic stEnable;
        logic disconnect;
        logic [3:0] offset;
        logic outEnable;
        logic outInvert;
        dacr_format_e format;
    } dacr_chan_cfg_s;

    localparam dacr_chan_cfg_s CHAN_CFG_RESET = '{
        testSel: TEST_OFF, rstLong: 1'b0, rstShort: 1'b0, stInit: 1'b0, stEnable: 1'b0,
        disconnect: 1'b0, offset: 4'h0, outEnable: 1'b0, outInvert: 1'b0,
        format: FMT_OFFSET_BIN};

endpackage

// [rtl/dacr_chan_if.sv]
// Active per-channel configuration and signature between the register bank and a channel.
interface dacr_chan_if;
    import dacr_pkg::*;
    dacr_chan_cfg_s cfg;
    logic powerDown;
    logic [SIG_W-1:0] signature;
    modport ctrl (output cfg, output powerDown, input signature);
    modport chan (input cfg, input powerDown, output signature);
endinterface

// [rtl/dacr_channel.sv]
// One converter channel's output path: trim, test patterns, formatting and signature.
module dacr_channel
    import dacr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    dacr_chan_if.chan cfgPort,
    input wire logic [DATA_W-1:0] sampleIn,
    input wire logic sampleValid,
    output logic [DATA_W-1:0] dataOut,
    output logic dataValid
);
    logic [LONG_LEN-1:0] longPrbs;
    logic [SHORT_LEN-1:0] shortPrbs;
    logic toggle;
    logic [SIG_W-1:0] signature;
    logic [DATA_W-1:0] trimmed;
    logic [DATA_W-1:0] patterned;
    logic [DATA_W-1:0] next_dataOut;
    logic [DATA_W+1:0] sum;

    // Offset binary sample plus signed trim, clamped at the ends of the range.
    always_comb begin
        sum = {2'b00, (cfgPort.cfg.disconnect ? PAT_MIDSCALE : sampleIn)}
            + {{(DATA_W-2){cfgPort.cfg.offset[3]}}, cfgPort.cfg.offset};
        if (sum[DATA_W+1]) begin
            trimmed = PAT_NEG_FULL;
        end else if (sum[DATA_W]) begin
            trimmed = PAT_POS_FULL;
        end else begin
            trimmed = sum[DATA_W-1:0];
        end
    end

    always_comb begin
        unique case (cfgPort.cfg.testSel)
            TEST_OFF: patterned = trimmed;
            TEST_MIDSCALE: patterned = PAT_MIDSCALE;
            TEST_POS_FULL: patterned = PAT_POS_FULL;
            TEST_NEG_FULL: patterned = PAT_NEG_FULL;
            TEST_CHECKER: patterned = toggle ? PAT_CHECK_B : PAT_CHECK_A;
            TEST_LONG_PRBS: patterned = longPrbs[DATA_W-1:0];
            TEST_SHORT_PRBS: patterned = shortPrbs[DATA_W-1:0];
            TEST_TOGGLE: patterned = toggle ? PAT_POS_FULL : PAT_NEG_FULL;
        endcase
    end

    always_comb begin
        unique case (cfgPort.cfg.format)
            FMT_TWOS_COMP: next_dataOut = {~patterned[DATA_W-1], patterned[DATA_W-2:0]};
            FMT_GRAY: next_dataOut = patterned ^ (patterned >> 1);
            FMT_OFFSET_BIN, FMT_RESERVED: next_dataOut = patterned;
        endcase
        if (cfgPort.cfg.outInvert) begin
            next_dataOut = ~next_dataOut;
        end
    end

    // Generators sit at all ones while held in reset so they restart identically.
    always_ff @(posedge clk) begin
        if (!rstn || cfgPort.cfg.rstLong) begin
            longPrbs <= '1;
        end else if (sampleValid) begin
            longPrbs <= {longPrbs[LONG_LEN-2:0], longPrbs[LONG_LEN-1] ^ longPrbs[LONG_TAP-1]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || cfgPort.cfg.rstShort) begin
            shortPrbs <= '1;
        end else if (sampleValid) begin
            shortPrbs <= {shortPrbs[SHORT_LEN-2:0],
                          shortPrbs[SHORT_LEN-1] ^ shortPrbs[SHORT_TAP-1]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            toggle <= 1'b0;
        end else if (sampleValid) begin
            toggle <= ~toggle;
        end
    end

    // Nothing leaves the channel in power-down or with the output disabled.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataOut <= '0;
            dataValid <= 1'b0;
        end else begin
            dataValid <= sampleValid && cfgPort.cfg.outEnable && !cfgPort.powerDown;
            if (sampleValid && cfgPort.cfg.outEnable && !cfgPort.powerDown) begin
                dataOut <= next_dataOut;
            end
        end
    end

    // Signature folds in each emitted word; init wins over accumulation.
    always_ff @(posedge clk) begin
        if (!rstn || cfgPort.cfg.stInit) begin
            signature <= '0;
        end else if (cfgPort.cfg.stEnable && sampleValid && !cfgPort.powerDown) begin
            signature <= ({signature[SIG_W-2:0], 1'b0}
                ^ (signature[SIG_W-1] ? SIG_POLY : '0))
                ^ {{(SIG_W-DATA_W){1'b0}}, next_dataOut};
        end
    end

    assign cfgPort.signature = signature;

endmodule // dacr_channel

// [verification/dacr_top_sva.sv]
// Port-level assertions for the converter configuration register bank.
module dacr_top_sva
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic sampleValid,
    input wire logic dataValidA,
    input wire logic dataValidB,
    input wire logic [1:0] powerMode,
    input wire logic stabilizerEnable,
    input wire logic [4:0] referenceScale
);
    timeunit 1ns;
    timeprecision 100ps;
    import dacr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic xfer;
    assign xfer = regWrEn && regAddr == ADDR_TRANSFER && regWrData == TRANSFER_CMD;

    property p_reset_vals;
        !$past(rstn) |-> powerMode == PWR_RUN && stabilizerEnable && referenceScale == 5'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
    property p_ref_guard;
        $past(rstn) && $changed(referenceScale) |-> $past(xfer, 2);
    endproperty
    a_ref_guard: assert property (p_ref_guard) else $error("scale moved early");
    property p_mode_guard;
        $past(rstn) && !$stable(powerMode) |-> $past(xfer, 2);
    endproperty
    a_mode_guard: assert property (p_mode_guard) else $error("mode moved early");
    property p_stab_guard;
        $past(rstn) && $changed(stabilizerEnable) |-> $past(xfer, 2);
    endproperty
    a_stab_guard: assert property (p_stab_guard) else $error("stabilizer moved early");
    property p_ref_apply;
        regWrEn && regAddr == ADDR_REF_SCALE ##1 xfer |-> ##2
            referenceScale == $past(regWrData[4:0], 3);
    endproperty
    a_ref_apply: assert property (p_ref_apply) else $error("scale not applied");
    property p_unmapped;
        regRdEn && regAddr == 8'h30 |=> regRdData == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_read_hold;
        !regRdEn |=> $stable(regRdData);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");
    property p_down_quiet;
        powerMode == PWR_DOWN && $past(powerMode) == PWR_DOWN |-> !dataValidA && !dataValidB;
    endproperty
    a_down_quiet: assert property (p_down_quiet) else $error("output while down");
    property p_valid_cause;
        dataValidA |-> $past(sampleValid) && $past(powerMode) != PWR_DOWN;
    endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("valid without sample");
endmodule // dacr_top_sva

bind dacr_top dacr_top_sva u_sva (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .sampleValid(sampleValid), .dataValidA(dataValidA), .dataValidB(dataValidB),
    .powerMode(powerMode), .stabilizerEnable(stabilizerEnable),
    .referenceScale(referenceScale)
);

// [verification/dacr_host_model.sv]
// Host model that drives the register port of the bank.
module dacr_host_model
(
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 100ps;
    import dacr_pkg::*;
    localparam time DLY = 2ns;
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic xfer);
        @(posedge clk);
        #DLY;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge clk);
        #DLY;
        if (xfer) begin
            // The strobe stays up so the transfer lands on the very next edge.
            regAddr = ADDR_TRANSFER;
            regWrData = TRANSFER_CMD;
            @(posedge clk);
            #DLY;
        end
        regWrEn = 1'b0;
        // Released lines must not keep looking valid.
        regAddr = ~regAddr;
        regWrData = ~regWrData;
        @(posedge clk);
        #DLY;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #DLY;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge clk);
        #DLY;
        regRdEn = 1'b0;
        regAddr = ~a;
        @(posedge clk);
        d = regRdData;
        #DLY;
    endtask
endmodule // dacr_host_model

// [verification/dacr_top_bench.sv]
// Self-checking bench for the converter configuration register bank.
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin nErrors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module dacr_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import dacr_pkg::*;
    localparam time DLY = 2ns;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData, rdv, sLo, sHi;
    logic regWrEn, regRdEn, sampleValid, dataValidA, dataValidB, stabilizerEnable;
    logic commonModeEnable, dataClockOutputInvert, analogDisconnectA, analogDisconnectB;
    logic [7:0] sampleA, sampleB, dataOutA, dataOutB;
    logic [1:0] powerMode;
    logic [4:0] referenceScale;
    int nErrors = 0;
    int checks = 0;
    logic [7:0] lo [8] = '{8'h10, 8'h80, 8'hff, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00};
    logic [7:0] hi [8] = '{8'h10, 8'h80, 8'hff, 8'h00, 8'haa, 8'h00, 8'h00, 8'hff};
    logic [7:0] tAd [10] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h14, 8'h14, 8'h14, 8'h14};
    logic [7:0] tVal [10] = '{8'h07, 8'h08, 8'h0f, 8'h07, 8'h08, 8'h00, 8'h11, 8'h12, 8'h14, 8'h13};
    logic [7:0] tIn [10] = '{8'h10, 8'h10, 8'h10, 8'hfe, 8'h03, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0] tExp [10] = '{8'h17, 8'h08, 8'h0f, 8'hff, 8'h00, 8'h10, 8'h90, 8'h18, 8'hef, 8'h10};

    always #12.5 clk = ~clk;

    dacr_top DUT (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .sampleA(sampleA), .sampleB(sampleB),
        .sampleValid(sampleValid), .dataOutA(dataOutA), .dataOutB(dataOutB),
        .dataValidA(dataValidA), .dataValidB(dataValidB), .powerMode(powerMode),
        .stabilizerEnable(stabilizerEnable), .commonModeEnable(commonModeEnable),
        .dataClockOutputInvert(dataClockOutputInvert), .referenceScale(referenceScale),
        .analogDisconnectA(analogDisconnectA), .analogDisconnectB(analogDisconnectB)
    );
    dacr_host_model host (
        .clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData)
    );

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rdv);
        `CHK(rdv, exp)
    endtask
    // One word to each channel; the result is looked at in its single valid cycle.
    task automatic samp(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk);
        #DLY;
        sampleA = a;
        sampleB = b;
        sampleValid = 1'b1;
        @(posedge clk);
        #DLY;
        sampleValid = 1'b0;
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        wrap_up();
    end

    initial begin
        sampleA = 8'h00;
        sampleB = 8'h00;
        sampleValid = 1'b0;
        repeat (6) @(posedge clk);
        #DLY;
        rstn = 1'b1;
        `CHK({powerMode, stabilizerEnable, referenceScale}, 8'h20)
        rdchk(ADDR_MODES, 8'h00);
        rdchk(ADDR_CLOCK, 8'h01);
        rdchk(ADDR_REF_SCALE, 8'h00);
        rdchk(ADDR_SIG_LOW, 8'h00);
        rdchk(ADDR_SIG_HIGH, 8'h00);
        rdchk(ADDR_TEST, 8'h00);
        rdchk(8'h30, 8'h00);
        host.wr(ADDR_REF_SCALE, 8'h05, 1'b0);
        host.wr(ADDR_TRANSFER, 8'h02, 1'b0);
        `CHK(referenceScale, 5'h00)
        rdchk(ADDR_REF_SCALE, 8'h05);
        host.wr(ADDR_TRANSFER, TRANSFER_CMD, 1'b0);
        `CHK(referenceScale, 5'h05)
        host.wr(ADDR_REF_SCALE, 8'hff, 1'b1);
        `CHK(referenceScale, 5'h1f)
        rdchk(ADDR_REF_SCALE, 8'h1f);
        host.wr(ADDR_CLOCK, 8'h00, 1'b1);
        host.wr(ADDR_OUT_PHASE, 8'h80, 1'b1);
        `CHK({stabilizerEnable, dataClockOutputInvert}, 2'b01)
        host.wr(ADDR_OUT_FORMAT, 8'h10, 1'b1);
        samp(8'h10, 8'h20);
        // Both valid bits high, then the untouched words of A and B.
        `CHK({dataValidA, dataValidB, dataOutA, dataOutB}, 18'h31020)
        for (int i = 0; i < 8; i++) begin
            host.wr(ADDR_TEST, 8'(i), 1'b1);
            samp(8'h10, 8'h10);
            if (i != 5 && i != 6) `CHK(dataOutA === lo[i] || dataOutA === hi[i], 1'b1)
        end
        host.wr(ADDR_TEST, 8'h25, 1'b1);
        repeat (2) samp(8'h10, 8'h10);
        `CHK(dataOutA, 8'hff)
        host.wr(ADDR_TEST, 8'h16, 1'b1);
        repeat (2) samp(8'h10, 8'h10);
        `CHK(dataOutB, 8'hff)
        host.wr(ADDR_TEST, 8'h00, 1'b1);
        for (int i = 0; i < 10; i++) begin
            host.wr(tAd[i], tVal[i], 1'b1);
            samp(tIn[i], tIn[i]);
            `CHK(dataOutA, tExp[i])
        end
        host.wr(ADDR_CHAN_INDEX, 8'h02, 1'b0);
        host.wr(ADDR_OFFSET, 8'h03, 1'b1);
        samp(8'h10, 8'h10);
        `CHK({dataOutA, dataOutB}, 16'h1013)
        rdchk(ADDR_OFFSET, 8'h03);
        host.wr(ADDR_CHAN_INDEX, 8'h01, 1'b0);
        host.wr(ADDR_INPUT, 8'h06, 1'b1);
        samp(8'h10, 8'h10);
        `CHK({analogDisconnectA, analogDisconnectB, commonModeEnable, dataOutA}, 11'h580)
        host.wr(ADDR_CHAN_INDEX, 8'h03, 1'b0);
        rdchk(ADDR_OFFSET, 8'h00);
        host.wr(ADDR_SELF_TEST, 8'h01, 1'b1);
        repeat (4) samp(8'h10, 8'h10);
        host.rd(ADDR_SIG_LOW, sLo);
        host.rd(ADDR_SIG_HIGH, sHi);
        // Four disconnected words of 0x80 from zero never reach the top bit, so no feedback.
        `CHK({sHi, sLo}, 16'h0780)
        host.wr(ADDR_SIG_LOW, 8'h5a, 1'b1);
        rdchk(ADDR_SIG_LOW, sLo);
        host.wr(ADDR_MODES, 8'h01, 1'b1);
        samp(8'h10, 8'h10);
        `CHK({powerMode, dataValidA, dataValidB}, 4'h4)
        rdchk(ADDR_SIG_HIGH, sHi);
        host.wr(ADDR_MODES, 8'h02, 1'b1);
        samp(8'h10, 8'h10);
        `CHK(dataValidA, 1'b1)
        host.wr(ADDR_SELF_TEST, 8'h05, 1'b1);
        samp(8'h10, 8'h10);
        rdchk(ADDR_SIG_LOW, 8'h00);
        rdchk(ADDR_SIG_HIGH, 8'h00);
        wrap_up();
    end
endmodule // dacr_top_bench
